//--- testbench/test_add_and_bit_ops_execute.sv
// Purpose: self-checking bench for the add, and, bit op execute stage
// Assumes: inputs change at the falling edge, results one clock later
// Notes:   a bench model of accumulator, flags and skip sets expectations
`timescale 1ns/10ps
module test_add_and_bit_ops_execute
  import exec_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk;
  logic        rst_n;
  logic        exec_s;
  logic [2:0]  op_sel;
  logic [7:0]  literal;
  logic [6:0]  file_addr;
  logic        dest;
  logic [2:0]  bit_sel;
  logic [7:0]  file_rdata;
  logic [7:0]  pin_level;
  logic        is_port;
  logic        acc_load;
  logic [7:0]  acc_load_data;
  logic        file_we;
  logic [6:0]  file_waddr;
  logic [7:0]  file_wdata;
  logic [7:0]  acc;
  logic        carry;
  logic        dcarry;
  logic        zero;
  logic        skip;
  logic [7:0]  m_acc;
  logic        m_c;
  logic        m_dc;
  logic        m_z;
  logic        m_skip;
  int          err_total;
  int          tests_run;

  add_and_bit_ops_execute u_dut (
    .CLK_I                     (clk),
    .NRST_I                    (rst_n),
    .EXEC_I                    (exec_s),
    .OP_SEL_I                  (op_sel),
    .LITERAL_I                 (literal),
    .FILE_ADDR_I               (file_addr),
    .DEST_I                    (dest),
    .BIT_SEL_I                 (bit_sel),
    .FILE_RDATA_I              (file_rdata),
    .PIN_LEVEL_I               (pin_level),
    .IS_PORT_I                 (is_port),
    .ACC_LOAD_I                (acc_load),
    .ACC_LOAD_DATA_I           (acc_load_data),
    .FILE_WE_O                 (file_we),
    .FILE_WADDR_O              (file_waddr),
    .FILE_WDATA_O              (file_wdata),
    .ACC_O                     (acc),
    .ARITH_OVERFLOW_OUT_FLAG_O (carry),
    .NIBBLE_OVERFLOW_FLAG_O    (dcarry),
    .NULL_RESULT_FLAG_O        (zero),
    .SKIP_O                    (skip)
  );

  // ---------------------------------------------------------------
  // compare and access tasks
  // ---------------------------------------------------------------
  // 4 ns clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task chk1(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // compares every output with the bench model, write address and data only when a write is expected
  task check_all(input logic we, input logic [6:0] wa, input logic [7:0] wd);
    chk1("write enable", we, file_we);
    if (we) begin
      chk8("write address", {1'b0, wa}, {1'b0, file_waddr});
      chk8("write data", wd, file_wdata);
    end
    chk8("accumulator", m_acc, acc);
    chk1("carry flag", m_c, carry);
    chk1("digit carry flag", m_dc, dcarry);
    chk1("zero flag", m_z, zero);
    chk1("skip request", m_skip, skip);
  endtask

  // one instruction, issued at a falling edge, checked one clock later
  task run(input logic [2:0] op, input logic [7:0] k, input logic [6:0] fa,
           input logic d, input logic [2:0] b, input logic [7:0] rd,
           input logic [7:0] pin, input logic prt);
    logic [8:0] s;
    logic [7:0] src;
    logic [7:0] r;
    logic       we;
    exec_s = 1'b1;
    op_sel = op;
    literal = k;
    file_addr = fa;
    dest = d;
    bit_sel = b;
    file_rdata = rd;
    pin_level = pin;
    is_port = prt;
    @(posedge clk);
    @(negedge clk);
    src = prt ? pin : rd;
    we = 1'b0;
    r = 8'h00;
    if (m_skip) begin
      m_skip = 1'b0;
    end else begin
      case (op)
        OP_ADD_IMM, OP_ADD_FILE: begin
          r = (op == OP_ADD_IMM) ? k : rd;
          s = {1'b0, m_acc} + {1'b0, r};
          m_c = s[8];
          m_dc = ({1'b0, m_acc[3:0]} + {1'b0, r[3:0]}) > 5'h0F;
          m_z = (s[7:0] == 8'h00);
          r = s[7:0];
        end
        OP_AND_IMM, OP_AND_FILE: begin
          r = m_acc & ((op == OP_AND_IMM) ? k : rd);
          m_z = (r == 8'h00);
        end
        OP_BIT_CLEAR: begin
          r = src & ~(8'h01 << b);
          we = 1'b1;
        end
        OP_BIT_SET: begin
          r = src | (8'h01 << b);
          we = 1'b1;
        end
        default: m_skip = src[b] ^ (op == OP_SKIP_LOW);
      endcase
      if (op < OP_BIT_CLEAR) begin
        if (op[0] && d) we = 1'b1;
        else m_acc = r;
      end
    end
    check_all(we, fa, r);
  endtask

  // idle cycle: no strobe, nothing may be written
  task gap;
    exec_s = 1'b0;
    @(posedge clk);
    @(negedge clk);
    check_all(1'b0, 7'h00, 8'h00);
  endtask

  task load(input logic [7:0] v);
    exec_s = 1'b0;
    acc_load = 1'b1;
    acc_load_data = v;
    @(posedge clk);
    @(negedge clk);
    acc_load = 1'b0;
    m_acc = v;
    check_all(1'b0, 7'h00, 8'h00);
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {exec_s, op_sel, literal, file_addr, dest, bit_sel} = '0;
    {file_rdata, pin_level, is_port, acc_load, acc_load_data} = '0;
    {m_acc, m_c, m_dc, m_z, m_skip} = '0;
    err_total = 0;
    tests_run = 0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check_all(1'b0, 7'h00, 8'h00);
    $display("reset test done");
    // digit carry, then carry with zero, back to back
    load(8'h0F);
    run(OP_ADD_IMM, 8'h01, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    run(OP_ADD_IMM, 8'hF0, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    run(OP_ADD_IMM, 8'hFF, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    $display("add immediate test done");
    load(8'h88);
    run(OP_ADD_FILE, 8'h00, 7'h7F, 1'b1, 3'h0, 8'h88, 8'h00, 1'b0);
    gap();
    run(OP_ADD_FILE, 8'h00, 7'h7F, 1'b0, 3'h0, 8'h77, 8'h00, 1'b0);
    $display("add file test done");
    run(OP_AND_IMM, 8'h0F, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    run(OP_AND_IMM, 8'hF0, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    load(8'h3C);
    run(OP_AND_FILE, 8'h00, 7'h40, 1'b1, 3'h0, 8'h0F, 8'h00, 1'b0);
    run(OP_AND_FILE, 8'h00, 7'h41, 1'b0, 3'h0, 8'hC3, 8'h00, 1'b0);
    $display("and test done");
    // every bit position, latch and port sources
    for (int i = 0; i < 8; i++) begin
      run(OP_BIT_CLEAR, 8'h00, 7'h05, 1'b0, 3'(i), 8'hFF, 8'h00, 1'b0);
      run(OP_BIT_SET, 8'h00, 7'h06, 1'b0, 3'(i), 8'h00, 8'hFF, 1'b0);
      run(OP_BIT_SET, 8'h00, 7'h07, 1'b0, 3'(i), 8'h00, 8'hA5, 1'b1);
      run(OP_BIT_CLEAR, 8'h00, 7'h07, 1'b0, 3'(i), 8'hFF, 8'h5A, 1'b1);
    end
    gap();
    $display("bit modify test done");
    // both tests, both bit levels; next add is dropped only when taken
    for (int i = 0; i < 4; i++) begin
      run(i[1] ? OP_SKIP_HIGH : OP_SKIP_LOW, 8'h00, 7'h09, 1'b0, 3'h4,
          i[0] ? 8'h10 : 8'h00, 8'h00, 1'b0);
      run(OP_ADD_IMM, 8'h01, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
      gap();
    end
    // taken test on port pins, skip held across idle cycles
    run(OP_SKIP_HIGH, 8'h00, 7'h0A, 1'b0, 3'h7, 8'h00, 8'h80, 1'b1);
    gap();
    gap();
    run(OP_ADD_IMM, 8'h01, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    run(OP_ADD_IMM, 8'h01, 7'h00, 1'b0, 3'h0, 8'h00, 8'h00, 1'b0);
    $display("skip test done");
    print_verdict();
  end
endmodule

//--- verilog/add_and_bit_ops_execute.sv
// Purpose: execute stage for add, and, bit clear, bit set, bit test
// Assumes: file read data and pin levels valid with EXEC_I
// Notes:   results appear one clock after EXEC_I
//
// Summary of operation
// - add immediate into accumulator, update three flags
// - add file register, destination bit picks target
// - and immediate into accumulator, zero flag only
// - and file register, destination bit, zero only
// - clear selected file register bit, flags kept
// - set selected file register bit, flags kept
// - bit low test: zero skips next, two cycles
// - bit low test: one runs next normally
// - bit high test: one skips next, two cycles
// - bit high test: zero no skip, flags kept
// - port bit ops read pins, not latch
`timescale 1ns/10ps
module add_and_bit_ops_execute
  import exec_pkg::*;
(
  // clock and reset
  input  wire logic              CLK_I,
  input  wire logic              NRST_I,
  // instruction
  input  wire logic              EXEC_I,
  input  wire logic [OP_W-1:0]   OP_SEL_I,
  input  wire logic [DATA_W-1:0] LITERAL_I,
  input  wire logic [ADDR_W-1:0] FILE_ADDR_I,
  input  wire logic              DEST_I,
  input  wire logic [BSEL_W-1:0] BIT_SEL_I,
  // file register read side
  input  wire logic [DATA_W-1:0] FILE_RDATA_I,
  input  wire logic [DATA_W-1:0] PIN_LEVEL_I,
  input  wire logic              IS_PORT_I,
  // accumulator load from the rest of the core
  input  wire logic              ACC_LOAD_I,
  input  wire logic [DATA_W-1:0] ACC_LOAD_DATA_I,
  // file register write side
  output logic                   FILE_WE_O,
  output logic [ADDR_W-1:0]      FILE_WADDR_O,
  output logic [DATA_W-1:0]      FILE_WDATA_O,
  // accumulator and status
  output logic [DATA_W-1:0]      ACC_O,
  output logic                   ARITH_OVERFLOW_OUT_FLAG_O,
  output logic                   NIBBLE_OVERFLOW_FLAG_O,
  output logic                   NULL_RESULT_FLAG_O,
  // skip request to the fetch logic
  output logic                   SKIP_O
);

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  skip_state_t       state_q;
  skip_state_t       state_d;
  logic              exec_ok;
  logic              is_add_imm;
  logic              is_add_file;
  logic              is_and_imm;
  logic              is_and_file;
  logic              is_bclr;
  logic              is_bset;
  logic              is_tlow;
  logic              is_thigh;
  logic              is_arith;
  logic              is_and;
  logic              is_bitwr;
  logic              to_file;

  // an instruction issued while a skip is pending is discarded
  assign exec_ok     = EXEC_I && (state_q == ST_RUN);
  assign is_add_imm  = exec_ok && (OP_SEL_I == OP_ADD_IMM);
  assign is_add_file = exec_ok && (OP_SEL_I == OP_ADD_FILE);
  assign is_and_imm  = exec_ok && (OP_SEL_I == OP_AND_IMM);
  assign is_and_file = exec_ok && (OP_SEL_I == OP_AND_FILE);
  assign is_bclr     = exec_ok && (OP_SEL_I == OP_BIT_CLEAR);
  assign is_bset     = exec_ok && (OP_SEL_I == OP_BIT_SET);
  assign is_tlow     = exec_ok && (OP_SEL_I == OP_SKIP_LOW);
  assign is_thigh    = exec_ok && (OP_SEL_I == OP_SKIP_HIGH);
  assign is_and      = is_and_imm || is_and_file;
  assign is_arith    = is_add_imm || is_add_file || is_and;
  assign is_bitwr    = is_bclr || is_bset;
  // destination bit only counts for the file forms
  assign to_file     = (is_add_file || is_and_file)
                       && (DEST_I == 1'(DEST_FILE));

  // ---------------------------------------------------------------
  // operand selection
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] alu_b;
  logic [DATA_W-1:0] bit_src;
  logic [DATA_W-1:0] alu_res;
  logic              alu_c;
  logic              alu_dc;
  logic              alu_z;
  logic [DATA_W-1:0] bit_res;
  logic              bit_val;

  // literal for immediate forms, file register otherwise
  assign alu_b   = (is_add_imm || is_and_imm) ? LITERAL_I
                                              : FILE_RDATA_I;
  // port registers are read from the pins
  assign bit_src = IS_PORT_I ? PIN_LEVEL_I : FILE_RDATA_I;

  add_and_unit #(
    .W (DATA_W)
  ) u_alu (
    .a_i        (ACC_O),
    .b_i        (alu_b),
    .and_mode_i (is_and),
    .res_o      (alu_res),
    .carry_o    (alu_c),
    .dcarry_o   (alu_dc),
    .zero_o     (alu_z)
  );

  bit_modify_unit #(
    .W (DATA_W)
  ) u_bit (
    .src_i     (bit_src),
    .bit_sel_i (BIT_SEL_I),
    .set_i     (is_bset),
    .res_o     (bit_res),
    .tested_o  (bit_val)
  );

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] acc_d;
  logic              c_d;
  logic              dc_d;
  logic              z_d;
  logic              we_d;
  logic [DATA_W-1:0] wdata_d;
  logic              skip_take;

  // accumulator gets add/and result unless sent to the file
  assign acc_d = (is_arith && !to_file) ? alu_res
               : ACC_LOAD_I             ? ACC_LOAD_DATA_I
               :                          ACC_O;
  // carries only from add; zero from add and and
  assign c_d  = (is_add_imm || is_add_file) ? alu_c
                                            : ARITH_OVERFLOW_OUT_FLAG_O;
  assign dc_d = (is_add_imm || is_add_file) ? alu_dc
                                            : NIBBLE_OVERFLOW_FLAG_O;
  assign z_d  = is_arith ? alu_z : NULL_RESULT_FLAG_O;
  // file write for file destination and bit modify
  assign we_d    = to_file || is_bitwr;
  assign wdata_d = is_bitwr ? bit_res : alu_res;
  // skip taken on tested bit matching the form
  assign skip_take = (is_tlow && !bit_val)
                  || (is_thigh && bit_val);

  // skip sequencer: one discarded instruction slot
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (skip_take) begin
          state_d = ST_SKIP;
        end
      end
      ST_SKIP: begin
        if (EXEC_I) begin
          state_d = ST_RUN; // slot executed as idle
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // skip state and request
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_q <= ST_RUN;
      SKIP_O  <= 1'b0;
    end else begin
      state_q <= state_d;
      SKIP_O  <= (state_d == ST_SKIP);
    end
  end

  // accumulator and status flags
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ACC_O                     <= ACC_RST;
      ARITH_OVERFLOW_OUT_FLAG_O <= 1'b0;
      NIBBLE_OVERFLOW_FLAG_O    <= 1'b0;
      NULL_RESULT_FLAG_O        <= 1'b0;
    end else begin
      ACC_O                     <= acc_d;
      ARITH_OVERFLOW_OUT_FLAG_O <= c_d;
      NIBBLE_OVERFLOW_FLAG_O    <= dc_d;
      NULL_RESULT_FLAG_O        <= z_d;
    end
  end

  // file register write port
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      FILE_WE_O    <= 1'b0;
      FILE_WADDR_O <= ADDR_RST;
      FILE_WDATA_O <= DATA_RST;
    end else begin
      FILE_WE_O    <= we_d;
      FILE_WADDR_O <= FILE_ADDR_I;
      FILE_WDATA_O <= wdata_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // add immediate lands in the accumulator
  a_add_imm_acc: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_add_imm |=> !FILE_WE_O
      && ACC_O == DATA_W'($past(ACC_O) + $past(LITERAL_I)))
    else $error("add immediate result wrong");

  // add to file writes back and keeps the accumulator
  a_add_file_wb: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_add_file && DEST_I && !ACC_LOAD_I |=> FILE_WE_O && $stable(ACC_O)
      && FILE_WDATA_O == DATA_W'($past(ACC_O) + $past(FILE_RDATA_I))
      && FILE_WADDR_O == $past(FILE_ADDR_I))
    else $error("add file writeback wrong");

  // and immediate leaves the carries alone
  a_and_imm_flags: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_and_imm |=> $stable(ARITH_OVERFLOW_OUT_FLAG_O)
      && $stable(NIBBLE_OVERFLOW_FLAG_O)
      && ACC_O == ($past(ACC_O) & $past(LITERAL_I)))
    else $error("and immediate flags or result wrong");

  // and file to accumulator does not write the file
  a_and_file_acc: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_and_file && !DEST_I |=> !FILE_WE_O
      && ACC_O == ($past(ACC_O) & $past(FILE_RDATA_I)))
    else $error("and file to accumulator wrong");

  // bit clear zeroes only the selected bit
  a_bit_clear: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_bclr && !IS_PORT_I |=> FILE_WE_O
      && FILE_WDATA_O == ($past(FILE_RDATA_I)
         & ~(DATA_W'(1) << $past(BIT_SEL_I)))
      && $stable(NULL_RESULT_FLAG_O))
    else $error("bit clear wrong");

  // bit set forces only the selected bit
  a_bit_set: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_bset && !IS_PORT_I |=> FILE_WE_O
      && FILE_WDATA_O == ($past(FILE_RDATA_I)
         | (DATA_W'(1) << $past(BIT_SEL_I)))
      && $stable(ARITH_OVERFLOW_OUT_FLAG_O))
    else $error("bit set wrong");

  // low test on a clear bit requests a skip
  a_skip_low: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_tlow && !bit_src[BIT_SEL_I] |=> SKIP_O && !FILE_WE_O)
    else $error("skip on low bit missed");

  // low test on a set bit does not skip
  a_noskip_low: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_tlow && bit_src[BIT_SEL_I] |=> !SKIP_O)
    else $error("unexpected skip on low test");

  // high test on a set bit requests a skip
  a_skip_high: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_thigh && bit_src[BIT_SEL_I] |=> SKIP_O)
    else $error("skip on high bit missed");

  // high test on a clear bit runs on, flags kept
  a_noskip_high: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_thigh && !bit_src[BIT_SEL_I] |=> !SKIP_O
      && $stable(NULL_RESULT_FLAG_O)
      && $stable(NIBBLE_OVERFLOW_FLAG_O))
    else $error("unexpected skip on high test");

  // discarded slot changes nothing and ends the skip
  a_skip_discard: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    SKIP_O && EXEC_I && !ACC_LOAD_I |=> !SKIP_O && !FILE_WE_O
      && $stable(ACC_O) && $stable(NULL_RESULT_FLAG_O))
    else $error("skipped instruction took effect");

  // port bit modify uses the pin levels
  a_port_source: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_bset && IS_PORT_I |=> FILE_WE_O
      && FILE_WDATA_O == ($past(PIN_LEVEL_I)
         | (DATA_W'(1) << $past(BIT_SEL_I))))
    else $error("port bit op did not use pins");

  // add flags follow carries out of bits 7 and 3
  a_add_flags: assert property (
    @(posedge CLK_I) disable iff (!NRST_I)
    is_add_imm |=> ARITH_OVERFLOW_OUT_FLAG_O
        == (({1'b0, $past(ACC_O)} + {1'b0, $past(LITERAL_I)}) > 9'h0FF)
      && NIBBLE_OVERFLOW_FLAG_O
        == (($past(ACC_O) & 8'h0F) + ($past(LITERAL_I) & 8'h0F) > 8'h0F)
      && NULL_RESULT_FLAG_O == (ACC_O == 8'h00))
    else $error("add flags wrong");

endmodule

//--- verilog/add_and_unit.sv
// Purpose: 8-bit adder and bitwise and with carry, digit carry, zero
// Assumes: purely combinational, used by the execute unit
// Notes:   zero follows the result in both modes, carries always come from the sum, caller picks which
`timescale 1ns/10ps
module add_and_unit
  import exec_pkg::*;
#(
  parameter int W = DATA_W
) (
  // operands
  input  wire logic [W-1:0] a_i,
  input  wire logic [W-1:0] b_i,
  input  wire logic         and_mode_i,
  // result and flags
  output logic [W-1:0]      res_o,
  output logic              carry_o,
  output logic              dcarry_o,
  output logic              zero_o
);

  logic [W:0]            full_sum;
  logic [NIBBLE_MSB+1:0] low_sum;

  // full width and low nibble sums
  assign full_sum = {1'b0, a_i} + {1'b0, b_i};
  assign low_sum  = {1'b0, a_i[NIBBLE_MSB:0]} + {1'b0, b_i[NIBBLE_MSB:0]};

  // select result and derive flags
  assign res_o    = and_mode_i ? (a_i & b_i) : full_sum[W-1:0];
  assign carry_o  = full_sum[W];
  assign dcarry_o = low_sum[NIBBLE_MSB+1];
  assign zero_o   = (res_o == '0);

endmodule

//--- verilog/bit_modify_unit.sv
// Purpose: single bit clear, set and test of a file register value
// Assumes: source already chosen between latch and pin levels
// Notes:   combinational
`timescale 1ns/10ps
module bit_modify_unit
  import exec_pkg::*;
#(
  parameter int W = DATA_W
) (
  // operand
  input  wire logic [W-1:0]      src_i,
  input  wire logic [BSEL_W-1:0] bit_sel_i,
  input  wire logic              set_i,
  // results
  output logic [W-1:0]           res_o,
  output logic                   tested_o
);

  logic [W-1:0] mask;

  // one-hot mask per bit position
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_mask
      assign mask[g] = (bit_sel_i == BSEL_W'(g));
    end
  endgenerate

  // modify selected bit, keep the others
  assign res_o    = set_i ? (src_i | mask) : (src_i & ~mask);
  assign tested_o = |(src_i & mask);

endmodule

//--- verilog/exec_pkg.sv
// Purpose: shared constants for the add, and and bit operation unit
// Assumes: one instruction presented per execute strobe
// Notes:   operation codes are the encoding of the OP_SEL_I port
package exec_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BSEL_W = 3;
  localparam int OP_W   = 3;

  // ---------------------------------------------------------------
  // operation select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_ADD_IMM    = 3'h0; // add_immediate
  localparam logic [2:0] OP_ADD_FILE   = 3'h1; // add_file_reg
  localparam logic [2:0] OP_AND_IMM    = 3'h2; // and_immediate
  localparam logic [2:0] OP_AND_FILE   = 3'h3; // and_file_reg
  localparam logic [2:0] OP_BIT_CLEAR  = 3'h4; // bit_clear_op
  localparam logic [2:0] OP_BIT_SET    = 3'h5; // bit_set_op
  localparam logic [2:0] OP_SKIP_LOW   = 3'h6; // skip_on_bit_low
  localparam logic [2:0] OP_SKIP_HIGH  = 3'h7; // skip_on_bit_high

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int NIBBLE_MSB = 3;  // digit carry leaves this bit
  localparam int DEST_FILE  = 1;  // destination bit value for file
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [6:0] ADDR_RST = 7'h00;

  // ---------------------------------------------------------------
  // skip sequencer states
  // ---------------------------------------------------------------
  typedef enum logic {
    ST_RUN,
    ST_SKIP
  } skip_state_t;

endpackage
